// [inc/scs_pkg.sv]
package scs_pkg;
   localparam logic [3:0] REG_REQ       = 4'h0;
   localparam logic [3:0] REG_CUR       = 4'h4;
   localparam logic [3:0] REG_SW        = 4'h8;
   localparam logic [3:0] REG_FLAG      = 4'hc;
   localparam int         SRC_LSB       = 4;
   localparam int         DIV_LSB       = 0;
   localparam int         HOLD_BIT      = 7;
   localparam int         DONE_BIT      = 4;
   localparam int         NOSR_BIT      = 3;
   localparam int         SWF_BIT       = 0;
   localparam int         OFF_BIT       = 1;
   localparam int         SWE_BIT       = 4;
   localparam int         OFE_BIT       = 5;
   localparam logic [2:0] SRC_EXT       = 3'h7;
   localparam logic [2:0] SRC_FAST      = 3'h6;
   localparam logic [2:0] SRC_SLOW      = 3'h5;
   localparam logic [2:0] SRC_XTAL      = 3'h4;
   localparam logic [2:0] SRC_PLL       = 3'h2;
   localparam logic [3:0] DIV_ONE       = 4'h0;
   localparam logic [3:0] DIV_FOUR      = 4'h2;
   localparam logic [3:0] DIV_MAX       = 4'h9;
   localparam int         OST_COUNT_DEF = 1024;
   localparam int         LF_DIV        = 64;
endpackage : scs_pkg

// [rtl/scs_clock_switch.sv]
`timescale 1ns/1ps
`default_nettype none
module scs_clock_switch #(
   parameter int OST_COUNT = scs_pkg::OST_COUNT_DEF,
   parameter int SAMPLE_DIV = scs_pkg::LF_DIV
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        switch_permit_config,
   input  wire logic        failsafe_monitor_config,
   input  wire logic [2:0]  reset_source_config,
   input  wire logic        external_clock_input,
   input  wire logic        ext_osc_ready,
   input  wire logic        pll_locked,
   input  wire logic        fast_osc_ready,
   input  wire logic        slow_osc_ready,
   input  wire logic        crystal_ready,
   input  wire logic        ext_clk_level,
   input  wire logic        slow_osc_tick,
   input  wire logic        cpu_cycle_en,
   input  wire logic        doze_active,
   input  wire logic        sleep_enter,
   input  wire logic        wake_up,
   output logic [2:0]       current_source,
   output logic [3:0]       current_divider,
   output logic             switch_irq,
   output logic             osc_fail_irq
);
   localparam int OSTW = $clog2(OST_COUNT + 1);
   localparam int HALF = SAMPLE_DIV / 2;
   localparam int LFW  = $clog2(HALF);
   localparam logic [OSTW-1:0] OST_END  = OSTW'(OST_COUNT);
   localparam logic [LFW-1:0]  HALF_END = LFW'(HALF - 1);

   typedef struct packed {
      logic            init;
      logic            ack;
      logic [31:0]     rdata;
      logic [2:0]      req_src;
      logic [3:0]      req_div;
      logic [2:0]      cur_src;
      logic [3:0]      cur_div;
      logic            nosr;
      logic            hold;
      logic            sw_flag;
      logic            sw_en;
      logic            of_flag;
      logic            of_en;
      logic            asleep;
      logic            wake_pend;
      logic            failsafe;
      logic            retry;
      logic [OSTW-1:0] ost_cnt;
      logic            ext_prev;
      logic [LFW-1:0]  lf_cnt;
      logic            sample;
      logic            latch;
      logic            armed;
      logic            sw_irq;
      logic            of_irq;
   } scs_state_t;

   scs_state_t q;
   scs_state_t d;

   logic       take;
   logic       wr;
   logic       wr_req;
   logic       pending;
   logic       ready;
   logic       ost_done;
   logic       monitor_on;
   logic       fail_event;
   logic       change;
   logic       sw_set;
   logic       ext_fall;
   logic       lf_wrap;
   logic [2:0] w_src;
   logic [3:0] w_div;

   function automatic logic is_ext(input logic [2:0] s);
      return (s == scs_pkg::SRC_EXT) || (s == scs_pkg::SRC_PLL);
   endfunction : is_ext

   function automatic logic src_valid(input logic [2:0] s);
      return is_ext(s) || (s == scs_pkg::SRC_FAST) || (s == scs_pkg::SRC_SLOW)
             || (s == scs_pkg::SRC_XTAL);
   endfunction : src_valid

   always_comb begin
      d = q;
      sw_set = 1'b0;
      take = wb_cyc_i && wb_stb_i && !q.ack;
      wr = take && wb_we_i && wb_sel_i[0];
      w_src = wb_dat_i[scs_pkg::SRC_LSB +: 3];
      w_div = wb_dat_i[scs_pkg::DIV_LSB +: 4];
      // reserved codes drop the whole write
      wr_req = wr && (wb_adr_i == scs_pkg::REG_REQ) && switch_permit_config
               && src_valid(w_src) && (w_div <= scs_pkg::DIV_MAX) && q.init;
      ext_fall = q.ext_prev && !ext_clk_level;
      ost_done = external_clock_input || (q.ost_cnt == OST_END);
      case (q.req_src)
         scs_pkg::SRC_EXT:  ready = ext_osc_ready && ost_done;
         scs_pkg::SRC_PLL:  ready = ext_osc_ready && ost_done && pll_locked;
         scs_pkg::SRC_FAST: ready = fast_osc_ready;
         scs_pkg::SRC_SLOW: ready = slow_osc_ready;
         scs_pkg::SRC_XTAL: ready = crystal_ready;
         default:           ready = 1'b0;
      endcase
      if (q.req_src == q.cur_src && !q.failsafe) begin
         ready = 1'b1;
      end
      // after a failure the request waits for a fresh write
      pending = ((q.req_src != q.cur_src) || (q.req_div != q.cur_div))
                && (!q.failsafe || q.retry) && q.init;
      d.ack = take;
      d.ext_prev = ext_clk_level;

      // sample clock: slow oscillator over SAMPLE_DIV
      lf_wrap = slow_osc_tick && (q.lf_cnt == HALF_END);
      if (slow_osc_tick) begin
         d.lf_cnt = lf_wrap ? '0 : q.lf_cnt + 1'b1;
      end
      if (lf_wrap) begin
         d.sample = !q.sample;
      end
      monitor_on = failsafe_monitor_config && q.init && !q.asleep && !q.failsafe
                   && (is_ext(q.cur_src) || q.cur_src == scs_pkg::SRC_XTAL)
                   && ost_done;
      // empty half-period with monitor armed means no low edge came
      fail_event = monitor_on && q.armed && lf_wrap && q.sample && !q.latch && !ext_fall;
      if (lf_wrap && !q.sample) begin
         d.latch = ext_fall; // set wins over the sample clear
         d.armed = monitor_on;
      end else if (ext_fall) begin
         d.latch = 1'b1;
      end
      if (!monitor_on) begin
         d.armed = 1'b0;
      end

      if (q.ost_cnt != OST_END && ext_fall) begin
         d.ost_cnt = q.ost_cnt + 1'b1;
      end

      // changeover at a whole-cycle boundary or in doze; after wake, as soon as the source is ready
      change = q.nosr && !q.hold && !q.asleep && pending
               && (doze_active || cpu_cycle_en);
      change = change || (q.wake_pend && !q.hold && pending && ready && !q.asleep);

      if (!pending || q.asleep) begin
         d.nosr = 1'b0;
      end else if (ready && !q.nosr) begin
         d.nosr = 1'b1;
         sw_set = 1'b1;
      end
      if (change) begin
         d.cur_src = q.req_src;
         d.cur_div = q.req_div;
         d.nosr = 1'b0;
         d.wake_pend = 1'b0;
         d.failsafe = 1'b0;
         d.retry = 1'b0;
         if (q.wake_pend) begin
            sw_set = 1'b1;
         end
      end
      if (q.wake_pend && (q.hold || !pending)) begin
         d.wake_pend = 1'b0;
      end

      if (fail_event) begin
         d.cur_src = scs_pkg::SRC_FAST; // divider kept
         d.failsafe = 1'b1;
         d.retry = 1'b0;
         d.nosr = 1'b0;
      end

      // bus writes; hardware sets below win over software clears
      d.rdata = '0;
      if (wr_req) begin
         d.req_src = w_src;
         d.req_div = w_div;
         if (is_ext(w_src)) begin
            d.ost_cnt = '0;
         end
         if (q.failsafe && is_ext(w_src)) begin
            d.retry = 1'b1;
         end else begin
            d.failsafe = 1'b0;
            d.retry = 1'b0;
         end
      end
      if (wr && wb_adr_i == scs_pkg::REG_SW) begin
         d.hold = wb_dat_i[scs_pkg::HOLD_BIT];
      end
      if (wr && wb_adr_i == scs_pkg::REG_FLAG) begin
         d.sw_flag = q.sw_flag && wb_dat_i[scs_pkg::SWF_BIT];
         d.of_flag = q.of_flag && wb_dat_i[scs_pkg::OFF_BIT];
         d.sw_en = wb_dat_i[scs_pkg::SWE_BIT];
         d.of_en = wb_dat_i[scs_pkg::OFE_BIT];
      end
      // set wins even when the flag was already up and is cleared now
      if (sw_set) begin
         d.sw_flag = 1'b1;
      end
      if (fail_event || d.failsafe) begin
         d.of_flag = 1'b1;
      end
      if (take && !wb_we_i) begin
         case (wb_adr_i)
            scs_pkg::REG_REQ: begin
               d.rdata[scs_pkg::SRC_LSB +: 3] = q.req_src;
               d.rdata[scs_pkg::DIV_LSB +: 4] = q.req_div;
            end
            scs_pkg::REG_CUR: begin
               d.rdata[scs_pkg::SRC_LSB +: 3] = q.cur_src;
               d.rdata[scs_pkg::DIV_LSB +: 4] = q.cur_div;
            end
            scs_pkg::REG_SW: begin
               d.rdata[scs_pkg::HOLD_BIT] = q.hold;
               d.rdata[scs_pkg::DONE_BIT] = !pending && !q.failsafe;
               d.rdata[scs_pkg::NOSR_BIT] = q.nosr;
            end
            scs_pkg::REG_FLAG: begin
               d.rdata[scs_pkg::SWF_BIT] = q.sw_flag;
               d.rdata[scs_pkg::OFF_BIT] = q.of_flag;
               d.rdata[scs_pkg::SWE_BIT] = q.sw_en;
               d.rdata[scs_pkg::OFE_BIT] = q.of_en;
            end
            default: d.rdata = '0;
         endcase
      end

      // sleep clears new-source-ready and the fail-safe state; a pending changeover waits for wake
      if (sleep_enter && !q.asleep) begin
         d.asleep = 1'b1;
         d.nosr = 1'b0;
         d.wake_pend = 1'b0;
         d.failsafe = 1'b0;
         d.retry = 1'b0;
         d.cur_src = q.cur_src;
         d.cur_div = q.cur_div;
      end else if (wake_up && q.asleep) begin
         d.asleep = 1'b0;
         d.wake_pend = 1'b1;
         d.ost_cnt = '0; // timer reruns after wake
      end

      // strap captured by a clocked load after reset release
      if (!q.init) begin
         d.init = 1'b1;
         d.req_src = reset_source_config;
         d.cur_src = reset_source_config;
         d.req_div = (reset_source_config == scs_pkg::SRC_FAST) ? scs_pkg::DIV_FOUR
                                                                : scs_pkg::DIV_ONE;
         d.cur_div = d.req_div;
         d.ost_cnt = '0;
      end

      d.sw_irq = q.sw_flag && q.sw_en && !q.asleep;
      d.of_irq = q.of_flag && q.of_en;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign wb_dat_o        = q.rdata;
   assign wb_ack_o        = q.ack;
   assign current_source  = q.cur_src;
   assign current_divider = q.cur_div;
   assign switch_irq      = q.sw_irq;
   assign osc_fail_irq    = q.of_irq;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   logic [7:0] tick_cnt;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt <= '0;
      end else if (lf_wrap) begin
         tick_cnt <= '0;
      end else if (slow_osc_tick) begin
         tick_cnt <= tick_cnt + 8'h01;
      end
   end

   sequence s_ready_seen;
      !q.nosr ##1 q.nosr;
   endsequence

   sequence s_fail_seen;
      fail_event ##1 1'b1;
   endsequence

   a_locked_request: assert property (
      (q.init && wr && wb_adr_i == scs_pkg::REG_REQ && !switch_permit_config)
      |=> $stable(q.req_src) && $stable(q.req_div))
      else $error("request changed while switching not permitted");

   a_reserved_ignored: assert property (
      (q.init && wr && wb_adr_i == scs_pkg::REG_REQ && !src_valid(w_src))
      |=> $stable(q.req_src) && $stable(q.req_div))
      else $error("reserved source write altered request");

   a_ready_sets_flag: assert property (
      s_ready_seen |-> q.sw_flag)
      else $error("new-source-ready rose without switch flag");

   a_hold_keeps_clock: assert property (
      (q.hold && !fail_event && !q.wake_pend) |=> $stable(q.cur_src))
      else $error("clock changed while held");

   a_sleep_no_switch: assert property (
      (q.asleep && $past(q.asleep) && !(!q.init)) |-> $stable(q.cur_src))
      else $error("clock changed during sleep");

   a_doze_next_cycle: assert property (
      (q.nosr && !q.hold && !q.asleep && doze_active && pending && !fail_event
       && !sleep_enter && !wr_req) |=> (q.cur_src == $past(q.req_src)) && !q.nosr)
      else $error("doze changeover not on next cycle");

   a_fail_forces_fast: assert property (
      s_fail_seen |-> (q.cur_src == scs_pkg::SRC_FAST) && q.of_flag
      && $stable(q.cur_div))
      else $error("failure did not select fast internal oscillator");

   a_fail_flag_resets: assert property (
      q.failsafe |=> q.of_flag)
      else $error("fail flag stayed clear during failure");

   a_sample_period: assert property (
      slow_osc_tick |-> tick_cnt < 8'(HALF))
      else $error("sample divider overran half period");

   a_sleep_irq_quiet: assert property (
      q.asleep ##1 q.asleep |-> !q.sw_irq)
      else $error("switch interrupt raised during sleep");
endmodule : scs_clock_switch
`default_nettype wire

// [sim/scs_osc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scs_osc_model #(
   parameter int TICK = 5
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic ext_run,
   output logic      ext_clk_level,
   output logic      slow_osc_tick
);
   int cnt_q;
   // a dead crystal freezes at its last level: that is what the monitor must catch
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q         <= 0;
         ext_clk_level <= 1'b0;
         slow_osc_tick <= 1'b0;
      end else begin
         cnt_q         <= (cnt_q == TICK - 1) ? 0 : cnt_q + 1;
         slow_osc_tick <= (cnt_q == 0);
         if (ext_run) begin
            ext_clk_level <= ~ext_clk_level;
         end
      end
   end
endmodule : scs_osc_model
`default_nettype wire

// [sim/scs_clock_switch_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module scs_clock_switch_tb;
   logic        clk, reset_n, cyc, stb, we, ack, permit, ext_run, ext_rdy, slow_rdy;
   logic        cpu_en, gate, doze, sleep_p, wake_p, sw_irq, of_irq, ext_lvl, tick, ec_mode;
   logic [3:0]  adr, cur_div;
   logic [2:0]  cur_src;
   logic [31:0] dat_w, dat_r, rd;
   int          n_mismatch, checks_done, req, cur, d;

   scs_osc_model u_scs_osc_model (.clk(clk), .reset_n(reset_n), .ext_run(ext_run),
      .ext_clk_level(ext_lvl), .slow_osc_tick(tick));
   scs_clock_switch #(.OST_COUNT(8), .SAMPLE_DIV(4)) u_scs_clock_switch (
      .clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(dat_w), .wb_sel_i(4'hf), .wb_dat_o(dat_r), .wb_ack_o(ack),
      .switch_permit_config(permit), .failsafe_monitor_config(1'b1),
      .reset_source_config(scs_pkg::SRC_FAST), .external_clock_input(ec_mode),
      .ext_osc_ready(ext_rdy), .pll_locked(ext_rdy), .fast_osc_ready(1'b1),
      .slow_osc_ready(slow_rdy), .crystal_ready(ext_rdy), .ext_clk_level(ext_lvl),
      .slow_osc_tick(tick), .cpu_cycle_en(cpu_en), .doze_active(doze),
      .sleep_enter(sleep_p), .wake_up(wake_p), .current_source(cur_src),
      .current_divider(cur_div), .switch_irq(sw_irq), .osc_fail_irq(of_irq));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // instruction cycles arrive at random, gate lets a scenario silence them
   always @(posedge clk) begin
      cpu_en <= gate & (($urandom % 3) == 0);
   end

   task automatic test_done;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done

   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] v);
      int t;
      @(posedge clk);
      cyc   <= 1'b1;
      stb   <= 1'b1;
      we    <= w;
      adr   <= a;
      dat_w <= {24'h0, v};
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (ack !== 1'b1 && t < 50);
      if (t >= 50) n_mismatch++;
      rd = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   task automatic wr_req(input int v);
      wb(1'b1, scs_pkg::REG_REQ, v[7:0]);
      if (permit && v[6:4] inside {3'h7, 3'h6, 3'h5, 3'h4, 3'h2} && v[3:0] < 10) req = v;
   endtask : wr_req

   task automatic cmp_reg(input logic [3:0] a, input int e, input logic [7:0] m);
      wb(1'b0, a, 8'h00);
      checks_done++;
      if ((rd & {24'h0, m}) !== (e[31:0] & {24'h0, m})) begin
         n_mismatch++;
         $display("Error at %0t: reg %h read %h want %h", $time, a, rd, e);
      end
   endtask : cmp_reg

   task automatic cmp_out(input int e, input logic si, input logic oi);
      checks_done++;
      if ({cur_src, cur_div, sw_irq, of_irq} !== {e[6:0], si, oi}) begin
         n_mismatch++;
         $display("Error at %0t: outputs %h %h %b %b", $time, cur_src, cur_div, sw_irq, of_irq);
      end
   endtask : cmp_out

   task automatic wait_cur(input int e, input int n);
      int t;
      t = 0;
      while ({1'b0, cur_src, cur_div} !== e[7:0] && t < n) begin
         @(posedge clk);
         t++;
      end
      cur = e;
      cmp_out(e, sw_irq, of_irq);
   endtask : wait_cur

   initial begin
      #100us;
      n_mismatch++;
      test_done();
   end

   initial begin
      {cyc, stb, we, adr, dat_w, doze, sleep_p, wake_p, ext_run, ext_rdy} = '0;
      {reset_n, permit, gate, slow_rdy, ec_mode} = 5'b01111;
      n_mismatch = 0;
      checks_done = 0;
      d = $urandom(32'h7fb3cebd);
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      req = 32'h62;
      cur = 32'h62;
      cmp_reg(scs_pkg::REG_REQ, req, 8'hff);
      cmp_reg(scs_pkg::REG_CUR, cur, 8'hff);
      cmp_reg(scs_pkg::REG_SW, 32'h10, 8'hff);
      cmp_reg(4'h2, 0, 8'hff);
      // divider change parked until a changeover point appears
      d = $urandom % 10;
      if (d == 2) d = 9;
      gate <= 1'b0;
      wr_req(32'h60 | d);
      repeat (10) @(posedge clk);
      cmp_out(cur, 1'b0, 1'b0);
      cmp_reg(scs_pkg::REG_SW, 32'h08, 8'hff);
      doze <= 1'b1;
      wait_cur(req, 3);
      doze <= 1'b0;
      gate <= 1'b1;
      cmp_reg(scs_pkg::REG_SW, 32'h10, 8'hff);
      cmp_reg(scs_pkg::REG_FLAG, 32'h01, 8'hff);
      for (int s = 0; s < 4; s++) begin
         wr_req(s == 2 ? 32'h5c : s << 4);
         cmp_reg(scs_pkg::REG_REQ, req, 8'hff);
      end
      wb(1'b1, scs_pkg::REG_FLAG, 8'h30);
      wb(1'b1, scs_pkg::REG_SW, 8'h80);
      wr_req(32'h50);
      repeat (5) @(posedge clk);
      cmp_out(cur, 1'b1, 1'b0);
      cmp_reg(scs_pkg::REG_SW, 32'h88, 8'hff);
      wr_req(cur);
      cmp_reg(scs_pkg::REG_SW, 32'h90, 8'hff);
      wr_req(32'h50);
      wb(1'b1, scs_pkg::REG_SW, 8'h00);
      wait_cur(32'h50, 20);
      // fail-safe: run on the external clock, then kill it
      ext_rdy <= 1'b1;
      ext_run <= 1'b1;
      wr_req(32'h70);
      wait_cur(32'h70, 20);
      wb(1'b1, scs_pkg::REG_FLAG, 8'h30);
      repeat (100) @(posedge clk);
      cmp_out(cur, 1'b0, 1'b0);
      ext_run <= 1'b0;
      wait_cur(32'h60, 200);
      repeat (2) @(posedge clk);
      cmp_out(cur, 1'b0, 1'b1);
      wb(1'b1, scs_pkg::REG_FLAG, 8'h30);
      cmp_reg(scs_pkg::REG_FLAG, 32'h02, 8'h02);
      wr_req(32'h50);
      wait_cur(32'h50, 20);
      wb(1'b1, scs_pkg::REG_FLAG, 8'h30);
      cmp_reg(scs_pkg::REG_FLAG, 32'h00, 8'h03);
      // sleep before the new source is ready: no switch until wake
      // crystal mode from here: the start-up timer gates readiness
      ec_mode <= 1'b0;
      ext_rdy <= 1'b0;
      ext_run <= 1'b1;
      wr_req(32'h70);
      sleep_p <= 1'b1;
      @(posedge clk);
      sleep_p <= 1'b0;
      repeat (3) @(posedge clk);
      ext_rdy <= 1'b1;
      repeat (30) @(posedge clk);
      cmp_out(cur, 1'b0, 1'b0);
      wake_p <= 1'b1;
      @(posedge clk);
      wake_p <= 1'b0;
      repeat (8) @(posedge clk);
      cmp_out(cur, 1'b0, 1'b0);
      wait_cur(32'h70, 40);
      cmp_reg(scs_pkg::REG_FLAG, 32'h01, 8'h01);
      permit <= 1'b0;
      @(posedge clk);
      wr_req(32'h50);
      cmp_reg(scs_pkg::REG_REQ, req, 8'hff);
      test_done();
   end
endmodule : scs_clock_switch_tb
`default_nettype wire
